// ===== core/timing_defs.svh
`ifndef TIMING_DEFS_SVH
`define TIMING_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DIVCTL_OFFSET 12'h030
`define SYSCTL2_OFFSET 12'h034
`define STATUS_OFFSET 12'h038

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DIVCTL_SEL_BIT 5
`define SYSCTL2_KEEP_BIT 7
`define SYSCTL2_RSTREQ_BIT 5
`define SYSCTL2_IDLE_BIT 4
`define STATUS_IDLE_BIT 4
`define STATUS_DIV_LSB 8
`define DIVCTL_RESET 8'h00
`define SYSCTL2_RESET 8'h80

// ----------------------------------------------------------------
// Chain structure and taps
// ----------------------------------------------------------------
`define PRESCALE_STAGES 3
`define DIVIDER_STAGES 21
`define TAP_TC 2
`define TAP_TBT 14
`define TAP_WDT 16
`define INSTR_MIN_CYCLES 4'h1

`endif

// ===== core/timing_pkg.sv
package timing_pkg;

  typedef enum logic [1:0] {state_zero, state_one, state_two, state_three} mc_state_t;

  typedef enum logic {mode_run, mode_idle} op_mode_t;

endpackage

// ===== core/mc_if.sv
`timescale 1ns/1ps

interface mc_if;
  logic run;
  logic clear;
  logic instr_start;
  logic [3:0] instr_len;
  timing_pkg::mc_state_t state;
  logic cycle_end;
  logic instr_done;
  logic busy;

  modport ctrl (output run, output clear, output instr_start, output instr_len,
    input state, input cycle_end, input instr_done, input busy);
  modport seq (input run, input clear, input instr_start, input instr_len,
    output state, output cycle_end, output instr_done, output busy);
endinterface

// ===== core/machine_cycle_seq.sv
`timescale 1ns/1ps
`include "timing_defs.svh"

module machine_cycle_seq (
  input wire logic pclk,
  input wire logic presetn,
  mc_if.seq mci
);

  timing_pkg::mc_state_t state_r;
  logic cycle_end_r;
  logic busy_r;
  logic done_r;
  logic [3:0] cnt_r;

  assign mci.state = state_r;
  assign mci.cycle_end = cycle_end_r;
  assign mci.busy = busy_r;
  assign mci.instr_done = done_r;

  // ----------------------------------------------------------------
  // State counter, one state per main clock period
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= timing_pkg::state_zero;
    else if (mci.clear)
      state_r <= timing_pkg::state_zero; // R16
    else if (mci.run)
    begin
      case (state_r) // R7 R9
        timing_pkg::state_zero: state_r <= timing_pkg::state_one;
        timing_pkg::state_one: state_r <= timing_pkg::state_two;
        timing_pkg::state_two: state_r <= timing_pkg::state_three;
        timing_pkg::state_three: state_r <= timing_pkg::state_zero; // R16
        default: state_r <= timing_pkg::state_zero;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cycle_end_r <= 1'b0;
    else
      cycle_end_r <= !mci.clear && mci.run && state_r == timing_pkg::state_three;
  end

  // ----------------------------------------------------------------
  // Instruction length in whole machine cycles
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 4'h0;
    end
    else
    begin
      done_r <= 1'b0;
      if (mci.clear)
        busy_r <= 1'b0;
      else if (!busy_r && mci.instr_start)
      begin
        busy_r <= 1'b1;
        cnt_r <= (mci.instr_len == 4'h0) ? `INSTR_MIN_CYCLES : mci.instr_len; // R8
      end
      else if (busy_r && mci.run && state_r == timing_pkg::state_three)
      begin
        if (cnt_r == `INSTR_MIN_CYCLES)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1; // R8
        end
        else
          cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  a_state_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    !mci.clear && mci.run && state_r == timing_pkg::state_three
    |=> state_r == timing_pkg::state_zero ##0 cycle_end_r) else $error("state did not wrap"); // R16
  a_state_step: assert property (@(posedge pclk) disable iff (!presetn)
    !mci.clear && mci.run && state_r == timing_pkg::state_zero
    |=> state_r == timing_pkg::state_one) else $error("state did not advance"); // R7
  a_instr_one: assert property (@(posedge pclk) disable iff (!presetn)
    !busy_r && mci.instr_start && !mci.clear && mci.instr_len == 4'h1
    |=> busy_r) else $error("instruction not started"); // R8
  c_instr_done: cover property (@(posedge pclk) disable iff (!presetn) done_r);

endmodule

// ===== core/system_timing_generator.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "timing_defs.svh"

// Notes on behaviour
// R1 - The chain supplies the time base, watchdog and timer source clocks from the oscillator.
// R2 - The chain is a three-stage prescaler, a 21-stage divider and a machine-cycle counter.
// R3 - Any system reset clears every prescaler and divider stage to zero.
// R4 - Divider control bit 5 feeds the first divider stage with fc/4 when 0 and fc/8 when 1.
// R5 - Software writes zero to divider control bits 7, 6, 2, 1 and 0.
// R6 - Divider control bits 4 and 3 read as an undefined value.
// R7 - A machine cycle is four states, zero to three, each one main clock period long.
// R8 - An instruction takes a whole number of machine cycles, from one to fifteen.
// R9 - In single clock mode a machine cycle lasts four oscillator periods.
// R10 - The standby controller runs the oscillator and picks the main clock from sysctl2; here sysctl2 has no clock select.
// R11 - After any reset the block is in the run state with core and peripherals clocked.
// R12 - All execution and hardware activity follow the clocks from the timing chain.
// R13 - The halt bit 4 of sysctl2 stops core and watchdog clocks; peripherals keep running.
// R14 - An enabled interrupt ends the halt and restores core and watchdog clocks.
// R15 - Writing 0 to sysctl2 bit 7 or 1 to bit 5 raises an internal reset, clock kept running.
// R16 - The state counter wraps from three to zero and restarts at zero after reset.
// R17 - Timer and watchdog clocks are fixed divider taps, so the select moves them together.
module system_timing_generator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_irq,
  input wire logic instr_start,
  input wire logic [3:0] instr_len,
  output logic tbt_tick,
  output logic wdt_tick,
  output logic tc_tick,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_enable,
  output logic [1:0] mc_state,
  output logic mc_cycle_end,
  output logic instr_done,
  output logic idle_mode,
  output logic sys_reset_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [`PRESCALE_STAGES-1:0] ps_r;
  logic [`DIVIDER_STAGES-1:0] div_r;
  logic sel_r;
  timing_pkg::op_mode_t mode_r;
  logic soft_rst_r;
  logic osc_en_r;
  logic cpu_en_r;
  logic periph_en_r;
  logic tbt_r;
  logic wdt_r;
  logic tc_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic div_en;
  logic wr_acc;
  logic wr_sysctl2;
  logic rst_write;
  logic idle_r;

  mc_if mci ();

  machine_cycle_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .mci(mci)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic low_ones(input logic [`DIVIDER_STAGES-1:0] v, input int n);
    logic [`DIVIDER_STAGES-1:0] m;
    m = `DIVIDER_STAGES'((64'h1 << n) - 64'h1);
    return (v & m) == m;
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return addr_is(a, `DIVCTL_OFFSET) || addr_is(a, `SYSCTL2_OFFSET) ||
      addr_is(a, `STATUS_OFFSET);
  endfunction

  assign idle_r = (mode_r == timing_pkg::mode_idle);
  assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;
  assign wr_sysctl2 = wr_acc && addr_is(paddr, `SYSCTL2_OFFSET);
  assign rst_write = wr_sysctl2 && (!pwdata[`SYSCTL2_KEEP_BIT] ||
    pwdata[`SYSCTL2_RSTREQ_BIT]);

  // First divider stage input select
  assign div_en = sel_r ? (ps_r == 3'h7) : (ps_r[1:0] == 2'h3); // R4

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata_r <= 32'h0000_0000;
      if (addr_is(paddr, `DIVCTL_OFFSET))
        prdata_r[`DIVCTL_SEL_BIT] <= sel_r; // R6
      else if (addr_is(paddr, `SYSCTL2_OFFSET))
      begin
        prdata_r[`SYSCTL2_KEEP_BIT] <= 1'b1;
        prdata_r[`SYSCTL2_IDLE_BIT] <= idle_r;
      end
      else if (addr_is(paddr, `STATUS_OFFSET))
      begin
        prdata_r[1:0] <= 2'(mci.state);
        prdata_r[`STATUS_IDLE_BIT] <= idle_r;
        prdata_r[`STATUS_DIV_LSB +: `DIVIDER_STAGES] <= div_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_r <= 1'b0;
    else if (soft_rst_r)
      sel_r <= 1'b0;
    else if (wr_acc && addr_is(paddr, `DIVCTL_OFFSET))
      sel_r <= pwdata[`DIVCTL_SEL_BIT]; // R4 R5
  end

  // A wake that meets an idle write keeps the block running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= timing_pkg::mode_run; // R11
    else if (soft_rst_r)
      mode_r <= timing_pkg::mode_run; // R11
    else if (wake_irq)
      mode_r <= timing_pkg::mode_run; // R14
    else if (wr_sysctl2 && !rst_write && pwdata[`SYSCTL2_IDLE_BIT])
      mode_r <= timing_pkg::mode_idle; // R13
    else if (wr_sysctl2 && !rst_write)
      mode_r <= timing_pkg::mode_run;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= rst_write; // R15
  end

  // Oscillator runs from the first clock after hardware reset, in single clock mode, also through internal reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_en_r <= 1'b0;
    else
      osc_en_r <= 1'b1; // R10 R15
  end

  // ----------------------------------------------------------------
  // Prescaler and divider chain
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ps_r <= 3'h0; // R3
    else if (soft_rst_r)
      ps_r <= 3'h0; // R3
    else
      ps_r <= ps_r + 3'h1; // R2
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= 21'h000000; // R3
    else if (soft_rst_r)
      div_r <= 21'h000000; // R3
    else if (div_en)
      div_r <= div_r + 21'h000001; // R2
  end

  // Ticks mark the carry into the tapped stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tbt_r <= 1'b0;
      wdt_r <= 1'b0;
      tc_r <= 1'b0;
    end
    else
    begin
      tbt_r <= !soft_rst_r && div_en && low_ones(div_r, `TAP_TBT); // R1 R17
      wdt_r <= !soft_rst_r && div_en && low_ones(div_r, `TAP_WDT) && !idle_r; // R13 R17
      tc_r <= !soft_rst_r && div_en && low_ones(div_r, `TAP_TC); // R1 R17
    end
  end

  // ----------------------------------------------------------------
  // Main clock enables and machine cycles
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_en_r <= 1'b0;
      periph_en_r <= 1'b0;
    end
    else
    begin
      cpu_en_r <= !idle_r && !soft_rst_r; // R12 R13
      periph_en_r <= !soft_rst_r; // R13
    end
  end

  assign mci.run = cpu_en_r; // R12
  assign mci.clear = soft_rst_r; // R16
  assign mci.instr_start = instr_start && cpu_en_r;
  assign mci.instr_len = instr_len;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tbt_tick = tbt_r;
  assign wdt_tick = wdt_r;
  assign tc_tick = tc_r;
  assign cpu_clk_en = cpu_en_r;
  assign periph_clk_en = periph_en_r;
  assign osc_enable = osc_en_r;
  assign mc_state = 2'(mci.state);
  assign mc_cycle_end = mci.cycle_end;
  assign instr_done = mci.instr_done;
  assign idle_mode = idle_r;
  assign sys_reset_req = soft_rst_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_soft_reset_clear: assert property (soft_rst_r |=> ps_r == 3'h0 && div_r == 21'h000000
    && !idle_r) else $error("internal reset left chain or halt set"); // R3 R11
  a_reset_request: assert property (rst_write |=> soft_rst_r ##1 osc_en_r)
    else $error("reset write did not raise internal reset"); // R15
  a_div_fc4: assert property (!soft_rst_r && !sel_r && ps_r[1:0] == 2'h3 |=>
    div_r == $past(div_r) + 21'h000001) else $error("fc/4 step missing"); // R4
  a_div_fc8_hold: assert property (!soft_rst_r && sel_r && ps_r == 3'h3 |=>
    div_r == $past(div_r)) else $error("fc/8 stepped early"); // R4
  a_prescale_wrap: assert property (!soft_rst_r && ps_r == 3'h7 |=> ps_r == 3'h0)
    else $error("prescaler did not wrap"); // R2
  a_halt_gates: assert property (idle_r && !wake_irq && !soft_rst_r |=> !cpu_clk_en && !wdt_tick
    && periph_clk_en) else $error("halt did not gate clocks"); // R13
  a_wake_restore: assert property (idle_r && wake_irq && !soft_rst_r |=> !idle_r ##1
    cpu_clk_en) else $error("wake did not restore run"); // R14
  a_tap_cause: assert property (tbt_tick |-> $past(div_en) && low_ones($past(div_r), 14))
    else $error("time base tick without carry"); // R17
  a_divctl_read: assert property (psel && !penable && !pwrite && addr_is(paddr, 12'h030)
    |=> prdata[5] == $past(sel_r) && prdata[7:6] == 2'h0) else $error("bad select read"); // R6
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");

  c_enter_idle: cover property (!idle_r ##1 idle_r);
  c_wake: cover property (idle_r && wake_irq);
  c_soft_reset: cover property (soft_rst_r);
  c_fc8_tick: cover property (sel_r && tc_tick);

endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
`include "timing_defs.svh"

module tb;
  logic pclk, presetn, psel, penable, pwrite, wake_irq, instr_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] instr_len;
  logic pready, pslverr, erv, tbt_tick, wdt_tick, tc_tick, cpu_clk_en, periph_clk_en;
  logic osc_enable, mc_cycle_end, instr_done, idle_mode, sys_reset_req;
  logic [1:0] mc_state;
  int err_total, check_count, cyc_count, n;

  system_timing_generator dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_irq(wake_irq), .instr_start(instr_start),
    .instr_len(instr_len), .tbt_tick(tbt_tick), .wdt_tick(wdt_tick), .tc_tick(tc_tick),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
    .mc_state(mc_state), .mc_cycle_end(mc_cycle_end), .instr_done(instr_done),
    .idle_mode(idle_mode), .sys_reset_req(sys_reset_req));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return idle_mode;
      1: return cpu_clk_en;
      2: return sys_reset_req;
      3: return tc_tick;
      default: return instr_done;
    endcase
  endfunction

  // Counts falling edges until the chosen output reaches v
  task automatic wait_on(input int w, input logic v, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge pclk);
      cnt++;
    end while (pick(w) !== v && cnt < lim);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    chk("osc_enable", 32'h1, {31'h0, osc_enable});
    chk("cpu_clk_en", 32'h1, {31'h0, cpu_clk_en});
    chk("periph_clk_en", 32'h1, {31'h0, periph_clk_en});
    chk("idle_mode", 32'h0, {31'h0, idle_mode});
    apb(1'b0, `DIVCTL_OFFSET, 32'h0);
    chk("divctl reset", 32'h0, rdv & 32'h000000E7);
    chk("divctl err", 32'h0, {31'h0, erv});
    apb(1'b0, `SYSCTL2_OFFSET, 32'h0);
    chk("sysctl2 reset", 32'h80, rdv & 32'h000000F0);
  endtask

  task automatic t_machine_cycle();
    logic [1:0] prev;
    int ends;
    @(negedge pclk);
    prev = mc_state;
    ends = 0;
    repeat (16)
    begin
      @(negedge pclk);
      chk("mc_state step", {30'h0, prev + 2'h1}, {30'h0, mc_state});
      prev = mc_state;
      ends += int'(mc_cycle_end);
    end
    chk("cycle_end per 16", 32'h4, 32'(ends));
  endtask

  task automatic t_tick(input logic sel, input int exp);
    apb(1'b1, `DIVCTL_OFFSET, {26'h0, sel, 5'h0});
    apb(1'b0, `DIVCTL_OFFSET, 32'h0);
    chk("divctl select", {26'h0, sel, 5'h0}, rdv & 32'h000000E7);
    repeat (3) wait_on(3, 1'b1, 100, n);
    chk("tc_tick period", 32'(exp), 32'(n));
  endtask

  task automatic run_instr(input logic [3:0] len, output int cnt);
    int k;
    k = 0;
    do
    begin
      @(negedge pclk);
      k++;
    end while (mc_state !== 2'h0 && k < 10);
    @(posedge pclk);
    instr_start <= 1'b1;
    instr_len <= len;
    @(posedge pclk);
    instr_start <= 1'b0;
    wait_on(4, 1'b1, 100, cnt);
  endtask

  task automatic t_instr();
    int a, b, c;
    run_instr(4'h1, a);
    run_instr(4'hF, b);
    run_instr(4'h0, c);
    chk("instr 15 vs 1", 32'd56, 32'(b - a));
    chk("instr 0 vs 1", 32'(a), 32'(c));
  endtask

  task automatic t_halt();
    apb(1'b1, `SYSCTL2_OFFSET, 32'h90);
    wait_on(0, 1'b1, 4, n);
    chk("idle_mode set", 32'h1, {31'h0, idle_mode});
    wait_on(1, 1'b0, 4, n);
    chk("cpu_clk_en halt", 32'h0, {31'h0, cpu_clk_en});
    chk("periph halt", 32'h1, {31'h0, periph_clk_en});
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk("status halt", 32'h1, {31'h0, rdv[`STATUS_IDLE_BIT]});
    wait_on(3, 1'b1, 40, n);
    chk("tc_tick in halt", 32'h1, {31'h0, tc_tick});
    @(posedge pclk);
    wake_irq <= 1'b1;
    wait_on(0, 1'b0, 4, n);
    chk("idle_mode wake", 32'h0, {31'h0, idle_mode});
    wait_on(1, 1'b1, 4, n);
    chk("cpu_clk_en wake", 32'h1, {31'h0, cpu_clk_en});
    @(posedge pclk);
    wake_irq <= 1'b0;
  endtask

  task automatic t_sysreset(input logic [31:0] val);
    apb(1'b1, `DIVCTL_OFFSET, 32'h20);
    apb(1'b1, `SYSCTL2_OFFSET, val);
    wait_on(2, 1'b1, 4, n);
    chk("reset request", 32'h1, {31'h0, sys_reset_req});
    @(negedge pclk);
    chk("reset pulse", 32'h0, {31'h0, sys_reset_req});
    chk("state restart", 32'h0, {30'h0, mc_state});
    chk("osc kept", 32'h1, {31'h0, osc_enable});
    apb(1'b0, `DIVCTL_OFFSET, 32'h0);
    chk("select cleared", 32'h0, rdv & 32'h000000E7);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk("divider cleared", 32'h1, {31'h0, rdv[28:8] < 21'h4});
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h03C, 32'hFFFFFFFF);
    chk("unmapped write err", 32'h1, {31'h0, erv});
    apb(1'b0, 12'h03C, 32'h0);
    chk("unmapped read err", 32'h1, {31'h0, erv});
    chk("unmapped read data", 32'h0, rdv);
  endtask

  task automatic t_hw_reset();
    apb(1'b1, `DIVCTL_OFFSET, 32'h20);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("cpu after reset", 32'h1, {31'h0, cpu_clk_en});
    apb(1'b0, `DIVCTL_OFFSET, 32'h0);
    chk("select after reset", 32'h0, rdv & 32'h000000E7);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    cyc_count++;
    if (cyc_count == 20000)
    begin
      err_total++;
      finish_test();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, wake_irq, instr_start} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    instr_len = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    t_reset_vals();
    t_machine_cycle();
    t_tick(1'b0, 16);
    t_tick(1'b1, 32);
    t_instr();
    t_halt();
    t_sysreset(32'h00);
    t_sysreset(32'hA0);
    t_unmapped();
    t_hw_reset();
    finish_test();
  end
endmodule
